/* rtl/irq_arb_pkg.sv */
// constants shared by the interrupt and dma priority arbiter
// assumes apb register access and a cpu that flags instruction boundaries
package irq_arb_pkg;
  localparam int NUM_EXT = 8;
  localparam int NUM_PER = 4;
  localparam int NUM_CH  = 12;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_NEST   = 8'h04;
  localparam logic [7:0] OFS_EXTCFG = 8'h08;
  localparam logic [7:0] OFS_EXTPRI = 8'h0C;
  localparam logic [7:0] OFS_PERPRI = 8'h10;
  localparam logic [7:0] OFS_VECPTR = 8'h14;
  localparam logic [7:0] OFS_DMALEN = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // control, external config and dma length register fields
  localparam int CTL_CPL_LSB = 0;
  localparam int CTL_MODE    = 3;
  localparam int CTL_IEN     = 4;
  localparam int CTL_TLMASK  = 5;
  localparam int CTL_TLSRC   = 6;
  localparam int CTL_TLEN    = 7;
  localparam int EXT_EN_LSB  = 0;
  localparam int EXT_RISE_LSB = 8;
  localparam int EXT_PEND_LSB = 16;
  localparam int DMA_RF_BIT  = 16;
  // reset values
  localparam logic [2:0]  CPL_RESET  = 3'h7;
  localparam logic [7:0]  NEST_RESET = 8'h00;
  localparam logic [7:0]  VPTR_RESET = 8'h00;
  // fixed vectors, high byte at the even address; register file dma length limit
  localparam logic [7:0]  VEC_RESET = 8'h00;
  localparam logic [7:0]  VEC_DIV0  = 8'h02;
  localparam logic [7:0]  VEC_TOP   = 8'h04;
  localparam logic [15:0] DMA_RF_MAX = 16'h00DE;
  // stack push selectors
  localparam logic [1:0] PUSH_PC_LO = 2'h0;
  localparam logic [1:0] PUSH_PC_HI = 2'h1;
  localparam logic [1:0] PUSH_FLAGS = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_PUSH_LO = 3'h1,
    ST_PUSH_HI = 3'h3,
    ST_PUSH_FL = 3'h2,
    ST_LOAD    = 3'h6
  } entry_st_t;
endpackage

/* rtl/prio_arbiter.sv */
// fixed daisy-chain priority arbiter over all channels
// assumes three priority bits per channel, lower value wins
`timescale 1ns/10ps
`default_nettype none
module prio_arbiter (
  // requests and levels
  input  wire logic [irq_arb_pkg::NUM_CH-1:0]   req,
  input  wire logic [3*irq_arb_pkg::NUM_CH-1:0] prio,
  // winner
  output logic                                  found,
  output logic [3:0]                            idx,
  output logic [2:0]                            lvl
);
  // scanning downward with <= lets the lowest index win a tie
  always_comb
  begin
    found = 1'b0;
    idx   = 4'h0;
    lvl   = 3'h7;
    for (int i = irq_arb_pkg::NUM_CH - 1; i >= 0; i--)
    begin
      if (req[i] && (!found || prio[3*i +: 3] <= lvl))
      begin
        found = 1'b1;
        idx   = 4'(i);
        lvl   = prio[3*i +: 3];
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/ext_edge_latch.sv */
// external interrupt pins: synchroniser, edge select, pending latch
// assumes asynchronous pins and a one-cycle clear mask
`timescale 1ns/10ps
`default_nettype none
module ext_edge_latch (
  // clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // pins and control
  input  wire logic [irq_arb_pkg::NUM_EXT-1:0]  pin,
  input  wire logic [irq_arb_pkg::NUM_EXT-1:0]  rise_sel,
  input  wire logic [irq_arb_pkg::NUM_EXT-1:0]  clr,
  // latched requests
  output logic      [irq_arb_pkg::NUM_EXT-1:0]  pend
);
  logic [irq_arb_pkg::NUM_EXT-1:0] meta;
  logic [irq_arb_pkg::NUM_EXT-1:0] sync;
  logic [irq_arb_pkg::NUM_EXT-1:0] prev;

  genvar g;
  generate
    for (g = 0; g < irq_arb_pkg::NUM_EXT; g++)
    begin : ch
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta[g] <= 1'b0;
          sync[g] <= 1'b0;
          prev[g] <= 1'b0;
          pend[g] <= 1'b0;
        end
        else
        begin
          meta[g] <= pin[g];
          sync[g] <= meta[g];
          prev[g] <= sync[g];
          // a new edge wins over a clear in the same cycle
          if (rise_sel[g] ? (sync[g] && !prev[g]) : (!sync[g] && prev[g]))
            pend[g] <= 1'b1;
          else if (clr[g])
            pend[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/interrupt_dma_priority_arbiter.sv */
// central interrupt and dma priority arbiter with apb registers
// assumes instr_end pulses at each instruction boundary, same clock
//
// Contract
// - an event suspends the program only when enabled and granted by priority
// - interrupt status is saved only after the current instruction completes
// - a granted dma request runs at the end of the current instruction
// - up to eight external channels, each with selectable trigger edge
// - top channel comes from the pseudo non-maskable pin or timer/watchdog
// - dma blocks up to 64k bytes; register file target at most 222
// - service routine addresses come from the first 256 program locations
// - fixed vectors: reset at 0, divide trap at 2, top level at 4
// - shared vector register: software upper bits, hardware lower bits
// - each vector register sits in its owner's register page
// - each channel has a 3-bit level, 0 highest and 7 lowest
// - a ninth level above all is reserved for the top source
// - equal levels are resolved by a fixed daisy chain
// - one level field serves irq and dma; dma wins a tie
// - a top level routine is never preempted in any mode; a divide trap still enters during it
// - the top source is configurable maskable or non-maskable
// - the current priority level resets to 7
// - an interrupt must beat the current level; dma may equal it
// - entry clears enable, pushes pc low, pc high, flags, loads pc
// - control bit 3 picks concurrent or nested; nested saves the level
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module interrupt_dma_priority_arbiter (
  // clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // apb slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [7:0]                       paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // external sources
  input  wire logic [irq_arb_pkg::NUM_EXT-1:0]  ext_pin,
  input  wire logic                             nmi_pin,
  input  wire logic                             timer_wdt_req,
  // on-chip peripherals
  input  wire logic [irq_arb_pkg::NUM_PER-1:0]  periph_irq_req,
  input  wire logic [irq_arb_pkg::NUM_PER-1:0]  periph_dma_req,
  input  wire logic [7:0]                       periph_vector,
  output logic      [irq_arb_pkg::NUM_PER-1:0]  periph_irq_ack,
  output logic      [irq_arb_pkg::NUM_PER-1:0]  periph_dma_ack,
  // cpu core
  input  wire logic                             instr_end,
  input  wire logic                             div_trap,
  input  wire logic                             iret,
  output logic                                  cpu_hold,
  output logic                                  stack_push,
  output logic      [1:0]                       push_sel,
  output logic                                  pc_load,
  output logic      [7:0]                       vector_addr
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  central_irq_control_reg;
  logic [7:0]  nesting_level_stack_reg;
  logic [7:0]  ext_en;
  logic [7:0]  ext_rise;
  logic [23:0] ext_prio;
  logic [11:0] per_prio;
  logic [7:0]  vector_pointer_reg;
  logic [15:0] dma_len;
  logic        dma_to_rf;
  logic        top_pend;
  logic        top_busy;
  logic        div_pend;
  logic [2:0]  nmi_sync;
  irq_arb_pkg::entry_st_t state;

  logic [2:0]  current_priority_level;
  logic        arbitration_mode_select;
  logic        global_irq_enable;
  logic        top_level_maskable;
  logic        top_src_timer;
  logic        top_en;

  assign current_priority_level  = central_irq_control_reg[2:0];
  assign arbitration_mode_select = central_irq_control_reg[irq_arb_pkg::CTL_MODE];
  assign global_irq_enable       = central_irq_control_reg[irq_arb_pkg::CTL_IEN];
  assign top_level_maskable      = central_irq_control_reg[irq_arb_pkg::CTL_TLMASK];
  assign top_src_timer           = central_irq_control_reg[irq_arb_pkg::CTL_TLSRC];
  assign top_en                  = central_irq_control_reg[irq_arb_pkg::CTL_TLEN];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, read data captured in the setup cycle, writes in the access cycle
  logic wr_en;
  logic setup;
  logic hit;

  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite;

  always_comb
  begin
    case (paddr)
      irq_arb_pkg::OFS_CTRL,
      irq_arb_pkg::OFS_NEST,
      irq_arb_pkg::OFS_EXTCFG,
      irq_arb_pkg::OFS_EXTPRI,
      irq_arb_pkg::OFS_PERPRI,
      irq_arb_pkg::OFS_VECPTR,
      irq_arb_pkg::OFS_DMALEN,
      irq_arb_pkg::OFS_STATUS: hit = 1'b1;
      default:                 hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // external channels and top source
  logic [7:0] ext_pend;
  logic [7:0] ext_clr;
  logic [7:0] ack_ext;
  logic       dma_fault;

  assign ext_clr = ack_ext |
    ((wr_en && paddr == irq_arb_pkg::OFS_EXTCFG) ? pwdata[23:16] : 8'h00);

  ext_edge_latch u_ext (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin      (ext_pin),
    .rise_sel (ext_rise),
    .clr      (ext_clr),
    .pend     (ext_pend)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nmi_sync <= 3'h0;
    else
      nmi_sync <= {nmi_sync[1:0], nmi_pin};
  end

  logic top_event;
  assign top_event = top_src_timer ? timer_wdt_req
                                   : (nmi_sync[1] && !nmi_sync[2]);

  // register file dma targets are limited in block length
  assign dma_fault = dma_to_rf && (dma_len > irq_arb_pkg::DMA_RF_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // arbitration across interrupt and dma requests
  logic [11:0] irq_req;
  logic [11:0] dma_req;
  logic [35:0] all_prio;
  logic        irq_found;
  logic        dma_found;
  logic [3:0]  irq_idx;
  logic [3:0]  dma_idx;
  logic [2:0]  irq_lvl;
  logic [2:0]  dma_lvl;

  assign all_prio = {per_prio, ext_prio};
  // peripherals present one kind of request per event
  assign irq_req = {periph_irq_req, ext_pend & ext_en};
  assign dma_req = {periph_dma_req & {4{!dma_fault}}, 8'h00};

  prio_arbiter u_irq_arb (
    .req   (irq_req),
    .prio  (all_prio),
    .found (irq_found),
    .idx   (irq_idx),
    .lvl   (irq_lvl)
  );

  prio_arbiter u_dma_arb (
    .req   (dma_req),
    .prio  (all_prio),
    .found (dma_found),
    .idx   (dma_idx),
    .lvl   (dma_lvl)
  );

  logic boundary;
  logic top_ok;
  logic pick_dma;
  logic go_div;
  logic go_top;
  logic go_dma;
  logic go_irq;

  assign boundary = instr_end && state == irq_arb_pkg::ST_IDLE;
  // top level sits above all eight levels; maskable only when configured
  assign top_ok   = top_pend && !top_busy &&
                    (!top_level_maskable || (global_irq_enable && top_en));
  assign pick_dma = dma_found && (!irq_found || dma_lvl <= irq_lvl);
  assign go_div   = boundary && div_pend;
  assign go_top   = boundary && !div_pend && top_ok;
  // a routine at top level blocks irq and dma until it returns; a divide trap still enters
  assign go_dma   = boundary && !div_pend && !top_ok && !top_busy && pick_dma &&
                    dma_lvl <= current_priority_level;
  assign go_irq   = boundary && !div_pend && !top_ok && !top_busy && !pick_dma &&
                    irq_found && global_irq_enable &&
                    irq_lvl < current_priority_level;

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge pulses
  genvar g;
  generate
    for (g = 0; g < irq_arb_pkg::NUM_EXT; g++)
    begin : ext_ack
      assign ack_ext[g] = go_irq && irq_idx == 4'(g);
    end
    for (g = 0; g < irq_arb_pkg::NUM_PER; g++)
    begin : per_ack
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          periph_irq_ack[g] <= 1'b0;
          periph_dma_ack[g] <= 1'b0;
        end
        else
        begin
          periph_irq_ack[g] <= go_irq && irq_idx == 4'(g + irq_arb_pkg::NUM_EXT);
          periph_dma_ack[g] <= go_dma && dma_idx == 4'(g + irq_arb_pkg::NUM_EXT);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // entry sequence
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= irq_arb_pkg::ST_IDLE;
    else
    begin
      case (state)
        irq_arb_pkg::ST_IDLE:
          if (go_irq || go_top || go_div)
            state <= irq_arb_pkg::ST_PUSH_LO;
        irq_arb_pkg::ST_PUSH_LO: state <= irq_arb_pkg::ST_PUSH_HI;
        irq_arb_pkg::ST_PUSH_HI: state <= irq_arb_pkg::ST_PUSH_FL;
        irq_arb_pkg::ST_PUSH_FL: state <= irq_arb_pkg::ST_LOAD;
        irq_arb_pkg::ST_LOAD:    state <= irq_arb_pkg::ST_IDLE;
        default:                 state <= irq_arb_pkg::ST_IDLE;
      endcase
    end
  end

  assign cpu_hold   = state != irq_arb_pkg::ST_IDLE;
  assign stack_push = state == irq_arb_pkg::ST_PUSH_LO ||
                      state == irq_arb_pkg::ST_PUSH_HI ||
                      state == irq_arb_pkg::ST_PUSH_FL;
  assign pc_load    = state == irq_arb_pkg::ST_LOAD;

  always_comb
  begin
    case (state)
      irq_arb_pkg::ST_PUSH_HI: push_sel = irq_arb_pkg::PUSH_PC_HI;
      irq_arb_pkg::ST_PUSH_FL: push_sel = irq_arb_pkg::PUSH_FLAGS;
      default:                 push_sel = irq_arb_pkg::PUSH_PC_LO;
    endcase
  end

  // vector table lives in the first 256 program bytes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vector_addr <= irq_arb_pkg::VEC_RESET;
    else if (go_div)
      vector_addr <= irq_arb_pkg::VEC_DIV0;
    else if (go_top)
      vector_addr <= irq_arb_pkg::VEC_TOP;
    else if (go_irq && irq_idx >= 4'(irq_arb_pkg::NUM_EXT))
      vector_addr <= periph_vector;
    else if (go_irq)
      vector_addr <= {vector_pointer_reg[7:4], irq_idx[2:0], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending top, trap and top-in-service flags; a set wins over a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      top_pend <= 1'b0;
      div_pend <= 1'b0;
      top_busy <= 1'b0;
    end
    else
    begin
      if (top_event)
        top_pend <= 1'b1;
      else if (go_top)
        top_pend <= 1'b0;
      if (div_trap)
        div_pend <= 1'b1;
      else if (go_div)
        div_pend <= 1'b0;
      if (go_top)
        top_busy <= 1'b1;
      else if (iret)
        top_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and nesting registers: hardware updates follow software writes
  logic       nest_any;
  logic [2:0] nest_low;

  always_comb
  begin
    nest_any = 1'b0;
    nest_low = 3'h7;
    for (int i = 7; i >= 0; i--)
    begin
      if (nesting_level_stack_reg[i])
      begin
        nest_any = 1'b1;
        nest_low = 3'(i);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      central_irq_control_reg <= {5'h00, irq_arb_pkg::CPL_RESET};
      nesting_level_stack_reg <= irq_arb_pkg::NEST_RESET;
    end
    else
    begin
      if (wr_en && paddr == irq_arb_pkg::OFS_CTRL)
        central_irq_control_reg <= pwdata[7:0];
      if (wr_en && paddr == irq_arb_pkg::OFS_NEST)
        nesting_level_stack_reg <= pwdata[7:0];
      if (go_irq || go_top || go_div)
        central_irq_control_reg[irq_arb_pkg::CTL_IEN] <= 1'b0;
      if (go_irq && arbitration_mode_select)
      begin
        nesting_level_stack_reg[current_priority_level] <= 1'b1;
        central_irq_control_reg[2:0] <= irq_lvl;
      end
      else if (iret)
      begin
        central_irq_control_reg[irq_arb_pkg::CTL_IEN] <= 1'b1;
        if (arbitration_mode_select && nest_any && !top_busy)
        begin
          central_irq_control_reg[2:0] <= nest_low;
          nesting_level_stack_reg[nest_low] <= 1'b0;
        end
      end
    end
  end

  // remaining configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_en             <= 8'h00;
      ext_rise           <= 8'h00;
      ext_prio           <= 24'hFFFFFF;
      per_prio           <= 12'hFFF;
      vector_pointer_reg <= irq_arb_pkg::VPTR_RESET;
      dma_len            <= 16'h0000;
      dma_to_rf          <= 1'b0;
    end
    else if (wr_en)
    begin
      case (paddr)
        irq_arb_pkg::OFS_EXTCFG:
        begin
          ext_en   <= pwdata[7:0];
          ext_rise <= pwdata[15:8];
        end
        irq_arb_pkg::OFS_EXTPRI: ext_prio <= pwdata[23:0];
        irq_arb_pkg::OFS_PERPRI: per_prio <= pwdata[11:0];
        irq_arb_pkg::OFS_VECPTR: vector_pointer_reg <= {pwdata[7:4], 4'h0};
        irq_arb_pkg::OFS_DMALEN:
        begin
          dma_len   <= pwdata[15:0];
          dma_to_rf <= pwdata[irq_arb_pkg::DMA_RF_BIT];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and error captured in the setup cycle
  logic [31:0] rd_mux;

  always_comb
  begin
    case (paddr)
      irq_arb_pkg::OFS_CTRL:   rd_mux = {24'h000000, central_irq_control_reg};
      irq_arb_pkg::OFS_NEST:   rd_mux = {24'h000000, nesting_level_stack_reg};
      irq_arb_pkg::OFS_EXTCFG: rd_mux = {8'h00, ext_pend, ext_rise, ext_en};
      irq_arb_pkg::OFS_EXTPRI: rd_mux = {8'h00, ext_prio};
      irq_arb_pkg::OFS_PERPRI: rd_mux = {20'h00000, per_prio};
      irq_arb_pkg::OFS_VECPTR: rd_mux = {24'h000000, vector_pointer_reg};
      irq_arb_pkg::OFS_DMALEN: rd_mux = {15'h0000, dma_to_rf, dma_len};
      irq_arb_pkg::OFS_STATUS: rd_mux = {14'h0000, div_pend, top_pend, 3'h0, state,
                                         dma_fault, top_busy, vector_addr};
      default:                 rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= rd_mux;
      pslverr <= !hit;
    end
  end
endmodule
`default_nettype wire

/* verif/irq_arb_sva.sv */
// assertions on the arbiter's cpu and peripheral handshake ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module irq_arb_sva (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // cpu and peripheral side
  input wire logic       instr_end,
  input wire logic [3:0] periph_irq_ack,
  input wire logic [3:0] periph_dma_ack,
  input wire logic       cpu_hold,
  input wire logic       stack_push,
  input wire logic [1:0] push_sel,
  input wire logic       pc_load
);
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  sequence push_steps;
    stack_push && push_sel == irq_arb_pkg::PUSH_PC_LO ##1 stack_push && push_sel == irq_arb_pkg::PUSH_PC_HI
      ##1 stack_push && push_sel == irq_arb_pkg::PUSH_FLAGS;
  endsequence
  sequence load_step;
    !stack_push && pc_load ##1 !pc_load;
  endsequence
  entry_order_a: assert property ($rose(cpu_hold) |-> push_steps ##1 load_step)
    else $error("entry out of order");
  hold_span_a: assert property ($rose(cpu_hold) |-> cpu_hold [*4] ##1 !cpu_hold)
    else $error("hold length wrong");
  boundary_only_a: assert property ($rose(cpu_hold) |-> $past(instr_end))
    else $error("entry off boundary");
  irq_entry_a: assert property (|periph_irq_ack |-> $rose(cpu_hold))
    else $error("irq ack without entry");
  dma_end_a: assert property (|periph_dma_ack |-> $past(instr_end) && !cpu_hold)
    else $error("dma ack off boundary");
  one_grant_a: assert property ($onehot0({periph_irq_ack, periph_dma_ack}))
    else $error("two grants");
  hold_quiet_a: assert property (cpu_hold && !$rose(cpu_hold) |-> !(|{periph_irq_ack, periph_dma_ack}))
    else $error("grant during entry");
  load_end_a: assert property ($fell(cpu_hold) |-> $past(pc_load))
    else $error("entry ended without load");
endmodule
bind interrupt_dma_priority_arbiter irq_arb_sva u_sva (.pclk(pclk), .presetn(presetn), .instr_end(instr_end),
  .periph_irq_ack(periph_irq_ack), .periph_dma_ack(periph_dma_ack), .cpu_hold(cpu_hold),
  .stack_push(stack_push), .push_sel(push_sel), .pc_load(pc_load));
`default_nettype wire

/* verif/periph_model.sv */
// peripheral stand-in: requests held until acked, one vector per channel
// assumes acks are one-cycle pulses from the arbiter
`timescale 1ns/10ps
`default_nettype none
module periph_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench commands
  input  wire logic [3:0] raise_irq,
  input  wire logic [3:0] raise_dma,
  // arbiter side
  input  wire logic [3:0] irq_ack,
  input  wire logic [3:0] dma_ack,
  output logic      [3:0] irq_req,
  output logic      [3:0] dma_req,
  output logic      [7:0] vector
);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_req <= 4'h0;
    else
      irq_req <= (irq_req & ~irq_ack) | raise_irq;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      dma_req <= 4'h0;
    else
      dma_req <= (dma_req & ~dma_ack) | raise_dma;
  // lowest pending channel shows its table entry
  always_comb
  begin
    vector = 8'h5A;
    for (int i = 3; i >= 0; i--)
      if (irq_req[i])
        vector = 8'h40 + 8'(2 * i);
  end
endmodule
`default_nettype wire

/* verif/interrupt_dma_priority_arbiter_tb_top.sv */
// self-checking bench for the interrupt and dma priority arbiter
// assumes the peripheral model and the bound checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) \
    begin \
      err_total++; \
      $display("BAD %0t got %h want %h", $time, a, e); \
    end \
  end
module interrupt_dma_priority_arbiter_tb_top;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [32:0] e;} row_t;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic        instr_end = 1'h0;
  logic        pready, pslverr, er, hold, cpu_hold;
  logic [2:0]  ev = 3'h0;
  logic [7:0]  paddr = 8'h00;
  logic [7:0]  ext_pin = 8'h02;
  logic [7:0]  pvec, vaddr;
  logic [3:0]  raise_irq = 4'h0;
  logic [3:0]  raise_dma = 4'h0;
  logic [3:0]  pirq, pdma, ia_w, da_w, ia, da;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [3:0]  chain [3] = '{4'h2, 4'h4, 4'h1};
  row_t        rows [6] = '{
    '{irq_arb_pkg::OFS_VECPTR, 32'hFF, 33'hF0},
    '{irq_arb_pkg::OFS_EXTPRI, 32'hFFFFFFFF, 33'hFFFFFF},
    '{irq_arb_pkg::OFS_PERPRI, 32'hFFFFFFFF, 33'hFFF},
    '{irq_arb_pkg::OFS_NEST, 32'h1AA, 33'hAA},
    '{irq_arb_pkg::OFS_DMALEN, 32'hFFFFFFFF, 33'h1FFFF},
    '{8'h24, 32'h1, 33'h100000000}};
  always #5 pclk = ~pclk;
  interrupt_dma_priority_arbiter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pin(ext_pin), .nmi_pin(ev[2]), .timer_wdt_req(ev[2]), .periph_irq_req(pirq), .periph_dma_req(pdma),
    .periph_vector(pvec), .periph_irq_ack(ia_w), .periph_dma_ack(da_w), .instr_end(instr_end),
    .div_trap(ev[0]), .iret(ev[1]), .cpu_hold(cpu_hold), .stack_push(), .push_sel(), .pc_load(),
    .vector_addr(vaddr));
  periph_model u_per (.pclk(pclk), .presetn(presetn), .raise_irq(raise_irq), .raise_dma(raise_dma),
    .irq_ack(ia_w), .dma_ack(da_w), .irq_req(pirq), .dma_req(pdma), .vector(pvec));
  ////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [32:0] e);
    apb(1'h0, a, 32'h0);
    `CHK({er, rd}, e)
  endtask
  // cpu events: bit 0 divide trap, bit 1 return, bit 2 nmi pin and timer
  task automatic pulse(input logic [2:0] v, input logic [3:0] i, input logic [3:0] d);
    @(posedge pclk);
    ev <= v;
    raise_irq <= i;
    raise_dma <= d;
    @(posedge pclk);
    ev <= 3'h0;
    raise_irq <= 4'h0;
    raise_dma <= 4'h0;
  endtask
  task automatic bnd;
    int n;
    n = 0;
    @(posedge pclk);
    instr_end <= 1'h1;
    @(posedge pclk);
    instr_end <= 1'h0;
    #1;
    ia = ia_w;
    da = da_w;
    hold = cpu_hold;
    while (cpu_hold === 1'h1 && n < 9)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rchk(irq_arb_pkg::OFS_CTRL, 33'h7);
    rchk(irq_arb_pkg::OFS_PERPRI, 33'hFFF);
    foreach (rows[i])
    begin
      apb(1'h1, rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    $display("registers done");
    pulse(3'h1, 4'h0, 4'h0);
    bnd();
    `CHK({hold, vaddr}, {1'h1, irq_arb_pkg::VEC_DIV0})
    apb(1'h1, irq_arb_pkg::OFS_DMALEN, 32'h100DF);
    apb(1'h1, irq_arb_pkg::OFS_PERPRI, 32'hFDB);
    apb(1'h1, irq_arb_pkg::OFS_CTRL, 32'h13);
    pulse(3'h0, 4'h1, 4'h2);
    bnd();
    `CHK({ia, da}, 8'h00)
    apb(1'h1, irq_arb_pkg::OFS_DMALEN, 32'h100DE);
    bnd();
    `CHK({ia, da}, 8'h02)
    bnd();
    `CHK(ia, 4'h0)
    apb(1'h1, irq_arb_pkg::OFS_CTRL, 32'h14);
    bnd();
    `CHK(ia, 4'h1)
    $display("dma tie done");
    apb(1'h1, irq_arb_pkg::OFS_CTRL, 32'h7);
    pulse(3'h0, 4'h1, 4'h0);
    bnd();
    `CHK(ia, 4'h0)
    apb(1'h1, irq_arb_pkg::OFS_CTRL, 32'h17);
    bnd();
    `CHK({ia, vaddr}, 12'h140)
    rchk(irq_arb_pkg::OFS_CTRL, 33'h7);
    apb(1'h1, irq_arb_pkg::OFS_PERPRI, 32'hE95);
    pulse(3'h0, 4'h7, 4'h0);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'h1, irq_arb_pkg::OFS_CTRL, 32'h17);
      bnd();
      `CHK(ia, chain[k])
    end
    $display("levels done");
    apb(1'h1, irq_arb_pkg::OFS_NEST, 32'h0);
    apb(1'h1, irq_arb_pkg::OFS_CTRL, 32'h1F);
    pulse(3'h0, 4'h1, 4'h0);
    bnd();
    rchk(irq_arb_pkg::OFS_CTRL, 33'hD);
    rchk(irq_arb_pkg::OFS_NEST, 33'h80);
    pulse(3'h2, 4'h0, 4'h0);
    rchk(irq_arb_pkg::OFS_CTRL, 33'h1F);
    $display("nested done");
    apb(1'h1, irq_arb_pkg::OFS_EXTCFG, 32'h103);
    ext_pin <= 8'h01;
    repeat (4) @(posedge pclk);
    rchk(irq_arb_pkg::OFS_EXTCFG, 33'h30103);
    apb(1'h1, irq_arb_pkg::OFS_EXTCFG, 32'h30103);
    ext_pin <= 8'h00;
    repeat (4) @(posedge pclk);
    rchk(irq_arb_pkg::OFS_EXTCFG, 33'h103);
    apb(1'h1, irq_arb_pkg::OFS_EXTCFG, 32'h0);
    $display("edges done");
    apb(1'h1, irq_arb_pkg::OFS_PERPRI, 32'hFF8);
    apb(1'h1, irq_arb_pkg::OFS_CTRL, 32'hE7);
    pulse(3'h4, 4'h1, 4'h0);
    bnd();
    `CHK(hold, 1'h0)
    apb(1'h1, irq_arb_pkg::OFS_CTRL, 32'hC7);
    bnd();
    `CHK({hold, ia, vaddr}, {1'h1, 4'h0, irq_arb_pkg::VEC_TOP})
    apb(1'h1, irq_arb_pkg::OFS_CTRL, 32'hD7);
    bnd();
    `CHK(ia, 4'h0)
    pulse(3'h2, 4'h0, 4'h0);
    bnd();
    `CHK(ia, 4'h1)
    apb(1'h1, irq_arb_pkg::OFS_CTRL, 32'h87);
    pulse(3'h4, 4'h0, 4'h0);
    repeat (2) @(posedge pclk);
    bnd();
    `CHK(vaddr, irq_arb_pkg::VEC_TOP)
    $display("top level done");
    end_of_test();
  end
endmodule
`default_nettype wire
